// ### tb/msrc_bus_host.sv
// two-wire bus host and downstream target model for the configuration block
`timescale 1ns/10ps
module msrc_bus_host (
	// clock
	input wire logic mclk,
	// resolved bus wires
	input wire logic scl_w,
	input wire logic sda_w,
	// host drive, high means released
	output logic scl_drv,
	output logic sda_drv,
	output int stretch_cnt,
	// downstream target side
	input wire msrc_pkg::msrc_fwd_s fwd,
	output logic fwd_busy,
	output logic [7:0] fwd_rdata,
	output msrc_pkg::msrc_fwd_s last_fwd,
	output int fwd_cnt
);
	import msrc_pkg::*;
	localparam logic [7:0] DOWN_DATA = 8'h3C;
	int busy_cnt;
	// ------------------------------------------------------------------
	// host side
	// ------------------------------------------------------------------
	// lines only pulled low
	initial begin
		scl_drv = 1'b1;
		sda_drv = 1'b1;
		stretch_cnt = 0;
		fwd_cnt = 0;
		busy_cnt = 0;
		last_fwd = '0;
	end
	// phases of four cycles keep the three-cycle minimum
	task automatic half();
		repeat (4) @(negedge mclk);
	endtask
	task automatic bus_start();
		sda_drv = 1'b1;
		half();
		scl_drv = 1'b1;
		half();
		sda_drv = 1'b0;
		half();
		scl_drv = 1'b0;
		half();
	endtask
	task automatic bus_stop();
		sda_drv = 1'b0;
		half();
		scl_drv = 1'b1;
		half();
		sda_drv = 1'b1;
		half();
	endtask
	// waits while the target holds the clock low
	task automatic put_bit(input logic b, output logic r);
		sda_drv = b;
		half();
		scl_drv = 1'b1;
		@(negedge mclk);
		while (!scl_w && stretch_cnt < 5000) begin
			stretch_cnt++;
			@(negedge mclk);
		end
		half();
		r = sda_w;
		scl_drv = 1'b0;
		half();
	endtask
	// msb first, then the acknowledge slot
	task automatic put_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) put_bit(d[i], r);
		put_bit(1'b1, r);
		ack = !r;
	endtask
	task automatic get_byte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			put_bit(1'b1, r);
			d[i] = r;
		end
		put_bit(last, r);
	endtask
	// ------------------------------------------------------------------
	// downstream target: slow read answer, junk data while busy
	// ------------------------------------------------------------------
	// downstream target answers every forwarded byte, whatever its target address
	// busy outlasts the host's low phase so the clock stretch is seen
	always @(negedge mclk) begin
		if (fwd.valid) begin
			last_fwd <= fwd;
			fwd_cnt <= fwd_cnt + 1;
		end
		if (fwd.valid && !fwd.write) busy_cnt <= 20;
		else if (busy_cnt != 0) busy_cnt <= busy_cnt - 1;
	end
	assign fwd_busy = (busy_cnt != 0);
	assign fwd_rdata = fwd_busy ? ~DOWN_DATA : DOWN_DATA;
endmodule

// ### tb/tb_msrc_mode_config.sv
// self-checking bench of the mode strap and repeater configuration block
`timescale 1ns/10ps
module tb_msrc_mode_config;
	import msrc_pkg::*;
	logic mclk, reset_n, scl_out, scl_oe, sda_out, sda_oe, scl_drv, sda_drv;
	logic fwd_busy, int_in_n, local_int, int_out_n, int_oe, sec_in;
	logic [2:0] mode_strap;
	logic [3:0] addr_strap;
	logic [7:0] fwd_rdata, d;
	msrc_fwd_s fwd, last_fwd;
	msrc_audio_s audio;
	msrc_cfg_s cfg;
	int err_count, samples_checked, cycles, stretch_cnt, fwd_cnt;
	// rows as {freq, repeater, backward, second audio}
	logic [3:0] mode_tab [0:7] = '{4'h0, 4'h4, 4'h5, 4'h8, 4'h9, 4'hC, 4'hD, 4'hA};
	wire scl_w = scl_drv & (!scl_oe | scl_out);
	wire sda_w = sda_drv & (!sda_oe | sda_out);
	msrc_mode_config i_dut (.mclk(mclk), .reset_n(reset_n), .mode_strap(mode_strap),
		.address_strap_input(addr_strap), .scl_in(scl_w), .scl_out(scl_out),
		.scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe),
		.fwd(fwd), .fwd_busy(fwd_busy), .fwd_rdata(fwd_rdata),
		.first_audio_data(1'b1), .second_audio_data(sec_in), .audio_word_select(1'b0),
		.audio(audio), .interrupt_in_n(int_in_n), .local_int(local_int),
		.interrupt_out_n(int_out_n), .interrupt_out_oe(int_oe), .cfg(cfg));
	msrc_bus_host i_host (.mclk(mclk), .scl_w(scl_w), .sda_w(sda_w), .scl_drv(scl_drv),
		.sda_drv(sda_drv), .stretch_cnt(stretch_cnt), .fwd(fwd), .fwd_busy(fwd_busy),
		.fwd_rdata(fwd_rdata), .last_fwd(last_fwd), .fwd_cnt(fwd_cnt));
	// ------------------------------------------------------------------
	// clock and hang guard
	// ------------------------------------------------------------------
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// generous ceiling, bus traffic needs under ten thousand cycles
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 60000) begin
			err_count++;
			summarize();
		end
	end
	// ------------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------------
	task automatic check(input logic [17:0] seen, input logic [17:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic do_reset(input logic [2:0] m, input logic [3:0] a);
		@(negedge mclk);
		reset_n = 1'b0;
		mode_strap = m;
		addr_strap = a;
		repeat (8) @(negedge mclk);
		check(18'(cfg), 18'h0);
		check(18'(sda_oe), 18'h0);
		reset_n = 1'b1;
		repeat (4) @(negedge mclk);
	endtask
	// address, then two bytes, every one acknowledged
	task automatic bus_write(input logic [6:0] a, input logic [7:0] b0, input logic [7:0] b1);
		logic k0, k1, k2;
		i_host.bus_start();
		i_host.put_byte({a, 1'b0}, k0);
		i_host.put_byte(b0, k1);
		i_host.put_byte(b1, k2);
		i_host.bus_stop();
		check(18'({k0, k1, k2}), 18'h7);
		repeat (2) @(negedge mclk);
	endtask
	task automatic set_ptr(input logic [7:0] idx);
		logic k0, k1;
		i_host.bus_start();
		i_host.put_byte({7'h0C, 1'b0}, k0);
		i_host.put_byte(idx, k1);
		check(18'({k0, k1}), 18'h3);
	endtask
	task automatic bus_read(input logic [6:0] a, output logic [7:0] v);
		logic k;
		i_host.bus_start();
		i_host.put_byte({a, 1'b1}, k);
		i_host.get_byte(1'b1, v);
		i_host.bus_stop();
		check(18'(k), 18'h1);
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// ------------------------------------------------------------------
	// tests
	// ------------------------------------------------------------------
	initial begin
		logic k;
		reset_n = 1'b0;
		mode_strap = 3'h0;
		addr_strap = 4'h0;
		int_in_n = 1'b0;
		local_int = 1'b0;
		sec_in = 1'b1;
		// every mode row and address code, one past the last code too
		for (int i = 0; i < 10; i++) begin
			do_reset(3'(i), 4'(i));
			check(18'(cfg.mode), 18'(mode_tab[i % 8]));
			check(18'(cfg.video_18bit), 18'(mode_tab[i % 8][0]));
			check(18'(audio.second_data), 18'(mode_tab[i % 8][0]));
			check(18'(cfg.gpio_en), 18'h0);
			check(18'(cfg.dev_addr), 18'(i < 9 ? MSRC_ADDR_TABLE[i] : 7'h0C));
			check(18'(int_oe), 18'(mode_tab[i % 8][2]));
		end
		// last strap leaves the node in repeater mode
		// strap moves after capture, setting must hold
		mode_strap = 3'h0;
		repeat (4) @(negedge mclk);
		check(18'(cfg.mode), 18'h4);
		$display("test strap decode done");
		int_in_n = 1'b1;
		// address of a neighbour gets no acknowledge
		i_host.bus_start();
		i_host.put_byte({7'h0D, 1'b0}, k);
		i_host.bus_stop();
		check(18'(k), 18'h0);
		bus_write(7'h0C, MSRC_REG_MODE_OVR, 8'h07);
		check(18'(cfg.mode), 18'hC);
		bus_write(7'h0C, MSRC_REG_GPIO_EN, 8'h0A);
		check(18'(cfg.gpio_en), 18'hA);
		bus_write(7'h0C, MSRC_REG_SEC_AUDIO, 8'h01);
		check(18'({cfg.mode, cfg.video_18bit, audio.second_data}), 18'h37);
		sec_in = 1'b0;
		repeat (2) @(negedge mclk);
		check(18'(audio), 18'h4);
		bus_write(7'h0C, MSRC_REG_AUDIO_PATH, 8'h01);
		check(18'(cfg.audio_serial), 18'h1);
		set_ptr(MSRC_REG_GPIO_EN);
		bus_read(7'h0C, d);
		check(18'(d), 18'h0A);
		// status is read-only, the write is acknowledged and dropped
		bus_write(7'h0C, MSRC_REG_STATUS, 8'h00);
		set_ptr(MSRC_REG_STATUS);
		bus_read(7'h0C, d);
		check(18'(d), 18'hED);
		$display("test own registers done");
		// last alias slot points 0x30 at downstream 0x28
		bus_write(7'h0C, MSRC_REG_ALIAS_ID + 8'h02, 8'h60);
		bus_write(7'h0C, MSRC_REG_ALIAS_TGT + 8'h02, 8'h50);
		bus_write(7'h30, 8'hA5, 8'h5A);
		check(18'(fwd_cnt), 18'h2);
		check(18'(last_fwd), 18'({1'b1, 1'b1, 7'h28, 8'h5A}));
		bus_read(7'h30, d);
		check(18'(d), 18'h3C);
		check(18'(last_fwd[16:8]), 18'({1'b1, 1'b0, 7'h28}));
		check(18'(stretch_cnt > 4), 18'h1);
		$display("test alias forwarding done");
		local_int = 1'b1;
		repeat (2) @(negedge mclk);
		check(18'({int_oe, int_out_n}), 18'h2);
		local_int = 1'b0;
		int_in_n = 1'b0;
		repeat (2) @(negedge mclk);
		check(18'(int_oe), 18'h1);
		int_in_n = 1'b1;
		repeat (2) @(negedge mclk);
		check(18'({int_oe, scl_out, sda_out}), 18'h0);
		$display("test interrupt chain done");
		summarize();
	end
endmodule

// ### verilog/msrc_mode_config.sv
// mode strap decode, two-wire target, alias forwarding and interrupt chaining
//
// Function
// - configuration comes from mode strap or from an override register
// - secondary audio on means 18-bit video and second audio input enabled
// - spare-input GPIO only enabled by register, never by strap
// - three alias slots cover three transmitters per receiver, two levels deep
// - repeater mode forwards bus transactions to downstream targets
// - alias addresses reach downstream targets with duplicate addresses
// - repeater audio goes in blanking packets or over serial audio
// - interrupt output is active low, pulled up, driven only low
// - configuration goes over a two-wire serial control bus
// - target address is one of nine chosen by address strap, or register 0x00 bits 7:1 when its bit 0 is set
// - bus clock is sampled and can be driven (stretched)
// - both bus lines are open drain, only pulled low
// - register 0x12 bit 0 also selects secondary audio channel
// - each received write byte is acknowledged by pulling data low
`timescale 1ns/10ps
module msrc_mode_config (
	// clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// straps
	input wire logic [2:0] mode_strap,
	input wire logic [3:0] address_strap_input,
	// two-wire bus, open drain
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// downstream forwarding
	output msrc_pkg::msrc_fwd_s fwd,
	input wire logic fwd_busy,
	input wire logic [7:0] fwd_rdata,
	// audio
	input wire logic first_audio_data,
	input wire logic second_audio_data,
	input wire logic audio_word_select,
	output msrc_pkg::msrc_audio_s audio,
	// interrupt chaining
	input wire logic interrupt_in_n,
	input wire logic local_int,
	output logic interrupt_out_n,
	output logic interrupt_out_oe,
	// configuration
	output msrc_pkg::msrc_cfg_s cfg
);
	import msrc_pkg::*;

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	typedef struct packed {
		logic loaded;
		logic [2:0] mode_code;
		logic [3:0] addr_code;
		msrc_phase_e ph;
		msrc_phase_e after_ack;
		logic [3:0] cnt;
		logic [7:0] shift;
		logic rw;
		logic own;
		logic [1:0] alias_idx;
		logic [7:0] ptr;
		logic scl_q;
		logic sda_q;
		logic sda_oe;
		logic scl_oe;
		logic stretch;
		logic [MSRC_REG_NUM-1:0][7:0] regs;
		msrc_cfg_s cfg;
		msrc_audio_s audio;
		logic int_oe;
		msrc_fwd_s fwd;
	} msrc_state_s;

	msrc_state_s st;
	msrc_state_s next_st;
	msrc_mode_s strap_mode;
	logic [6:0] strap_addr;
	logic [6:0] dev_addr;
	logic [MSRC_ALIAS_NUM-1:0] alias_hit;
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	logic [7:0] rdval;

	// ------------------------------------------------------------------
	// strap decode
	// ------------------------------------------------------------------
	msrc_strap_decode u_decode (
		.mode_code(st.mode_code),
		.addr_code(st.addr_code),
		.mode(strap_mode),
		.addr(strap_addr)
	);

	// strap address unless register id takes over
	assign dev_addr = st.regs[MSRC_REG_DEV_ID][MSRC_BIT_ID_OVR] ?
		st.regs[MSRC_REG_DEV_ID][7:1] : strap_addr;

	// start and stop detection
	// bus events; lines are treated as synchronous inputs
	assign scl_rise = scl_in & ~st.scl_q;
	assign scl_fall = ~scl_in & st.scl_q;
	assign bus_start = scl_in & st.scl_q & st.sda_q & ~sda_in;
	assign bus_stop = scl_in & st.scl_q & ~st.sda_q & sda_in;

	// alias slot match, only live in repeater mode
	genvar gi;
	generate
		for (gi = 0; gi < MSRC_ALIAS_NUM; gi++) begin : g_alias
			assign alias_hit[gi] = st.cfg.mode.repeater &&
				(st.regs[MSRC_REG_ALIAS_ID + gi][7:1] != 7'h00) &&
				(st.regs[MSRC_REG_ALIAS_ID + gi][7:1] == st.shift[7:1]);
		end
	endgenerate

	// read data; status shows the live configuration
	always_comb begin
		if (st.ptr == MSRC_REG_STATUS) begin
			rdval = {st.loaded, st.cfg.audio_serial, st.cfg.video_18bit,
				st.int_oe, st.cfg.mode};
		end else if (st.ptr < MSRC_REG_NUM) begin
			rdval = st.regs[st.ptr[4:0]];
		end else begin
			rdval = MSRC_BYTE_ZERO;
		end
	end

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	always_comb begin
		msrc_mode_s sel;
		logic [7:0] ovr;
		logic go_read;
		sel = strap_mode;
		ovr = st.regs[MSRC_REG_MODE_OVR];
		go_read = 1'b0;
		next_st = st;
		next_st.fwd.valid = 1'b0;
		next_st.scl_q = scl_in;
		next_st.sda_q = sda_in;
		// one capture of the straps after reset release
		if (!st.loaded) begin
			next_st.loaded = 1'b1;
			next_st.mode_code = mode_strap;
			next_st.addr_code = address_strap_input;
		end
		if (bus_start) begin
			next_st.ph = MSRC_ST_ADDR;
			next_st.cnt = MSRC_CNT_ZERO;
			next_st.sda_oe = 1'b0;
		end else if (bus_stop) begin
			next_st.ph = MSRC_ST_IDLE;
			next_st.sda_oe = 1'b0;
			next_st.scl_oe = 1'b0;
			next_st.stretch = 1'b0;
		end else if (st.stretch) begin
			// hold clock low until downstream read data is back
			if (!fwd_busy) begin
				next_st.stretch = 1'b0;
				next_st.scl_oe = 1'b0;
				next_st.shift = fwd_rdata;
				next_st.sda_oe = ~fwd_rdata[7];
				next_st.cnt = MSRC_CNT_ONE;
			end
		end else if (scl_rise) begin
			if (st.ph == MSRC_ST_ADDR || st.ph == MSRC_ST_REG || st.ph == MSRC_ST_WDATA) begin
				next_st.shift = {st.shift[6:0], sda_in};
				next_st.cnt = st.cnt + MSRC_CNT_ONE;
			end else if (st.ph == MSRC_ST_MACK && sda_in) begin
				// host refused another byte: wait for stop
				next_st.ph = MSRC_ST_IDLE;
			end
		end else if (scl_fall) begin
			case (st.ph)
				MSRC_ST_ADDR: begin
					if (st.cnt == MSRC_BITS_BYTE) begin
						next_st.rw = st.shift[0];
						next_st.own = (st.shift[7:1] == dev_addr);
						next_st.alias_idx = 2'h0;
						for (int i = 0; i < MSRC_ALIAS_NUM; i++) begin
							if (alias_hit[i]) begin
								next_st.alias_idx = 2'(i);
							end
						end
						if (st.shift[7:1] == dev_addr || alias_hit != '0) begin
							next_st.sda_oe = 1'b1;
							next_st.ph = MSRC_ST_ACK;
							if (st.shift[0]) begin
								next_st.after_ack = MSRC_ST_RDATA;
							end else if (st.shift[7:1] == dev_addr) begin
								next_st.after_ack = MSRC_ST_REG;
							end else begin
								next_st.after_ack = MSRC_ST_WDATA;
							end
						end else begin
							next_st.ph = MSRC_ST_IDLE;
						end
					end
				end
				MSRC_ST_REG: begin
					if (st.cnt == MSRC_BITS_BYTE) begin
						next_st.ptr = st.shift;
						next_st.sda_oe = 1'b1;
						next_st.ph = MSRC_ST_ACK;
						next_st.after_ack = MSRC_ST_WDATA;
					end
				end
				MSRC_ST_WDATA: begin
					if (st.cnt == MSRC_BITS_BYTE) begin
						if (st.own) begin
							if (st.ptr < MSRC_REG_NUM && st.ptr != MSRC_REG_STATUS) begin
								next_st.regs[st.ptr[4:0]] = st.shift;
							end
							next_st.ptr = st.ptr + MSRC_PTR_ONE;
						end else begin
							// pass the byte through to the real target
							next_st.fwd.valid = 1'b1;
							next_st.fwd.write = 1'b1;
							next_st.fwd.data = st.shift;
							next_st.fwd.target = st.regs[MSRC_REG_ALIAS_TGT + st.alias_idx][7:1];
						end
						next_st.sda_oe = 1'b1;
						next_st.ph = MSRC_ST_ACK;
						next_st.after_ack = MSRC_ST_WDATA;
					end
				end
				MSRC_ST_RDATA: begin
					if (st.cnt == MSRC_BITS_BYTE) begin
						next_st.sda_oe = 1'b0;
						next_st.ph = MSRC_ST_MACK;
					end else begin
						next_st.shift = {st.shift[6:0], 1'b0};
						next_st.sda_oe = ~st.shift[6];
						next_st.cnt = st.cnt + MSRC_CNT_ONE;
					end
				end
				MSRC_ST_ACK: begin
					next_st.sda_oe = 1'b0;
					next_st.ph = st.after_ack;
					next_st.cnt = MSRC_CNT_ZERO;
					go_read = (st.after_ack == MSRC_ST_RDATA);
				end
				MSRC_ST_MACK: begin
					next_st.ph = MSRC_ST_RDATA;
					go_read = 1'b1;
				end
				default: begin
					next_st.sda_oe = 1'b0;
				end
			endcase
			if (go_read) begin
				if (st.own) begin
					next_st.shift = rdval;
					next_st.sda_oe = ~rdval[7];
					next_st.cnt = MSRC_CNT_ONE;
					next_st.ptr = st.ptr + MSRC_PTR_ONE;
				end else begin
					next_st.fwd.valid = 1'b1;
					next_st.fwd.write = 1'b0;
					next_st.fwd.data = MSRC_BYTE_ZERO;
					next_st.fwd.target = st.regs[MSRC_REG_ALIAS_TGT + st.alias_idx][7:1];
					next_st.stretch = 1'b1;
					next_st.scl_oe = 1'b1;
				end
			end
		end
		// override register replaces the strap-decoded mode
		if (ovr[MSRC_BIT_OVR_EN]) begin
			sel.freq_high = ovr[MSRC_BIT_OVR_FREQ];
			sel.repeater = ovr[MSRC_BIT_OVR_REP];
			sel.backward_compat = ovr[MSRC_BIT_OVR_BC];
			sel.second_audio = ovr[MSRC_BIT_OVR_CHB];
		end
		// register bit also turns on the secondary channel
		sel.second_audio = sel.second_audio | st.regs[MSRC_REG_SEC_AUDIO][MSRC_BIT_SEC_AUDIO];
		next_st.cfg.mode = sel;
		next_st.cfg.video_18bit = sel.second_audio;
		// spare inputs become GPIO by register only
		next_st.cfg.gpio_en = st.regs[MSRC_REG_GPIO_EN][MSRC_GPIO_W-1:0];
		// serial audio path only meaningful in repeater mode
		next_st.cfg.audio_serial = sel.repeater &
			st.regs[MSRC_REG_AUDIO_PATH][MSRC_BIT_AUDIO_SERIAL];
		next_st.cfg.dev_addr = dev_addr;
		// second audio input passes only when enabled
		next_st.audio.first_data = first_audio_data;
		next_st.audio.second_data = st.cfg.mode.second_audio & second_audio_data;
		next_st.audio.word_select = audio_word_select;
		// chain downstream interrupt, pull low only
		next_st.int_oe = (st.cfg.mode.repeater & ~interrupt_in_n) | local_int;
	end

	// state register
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			st <= '0;
			st.scl_q <= 1'b1;
			st.sda_q <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// lines only ever pulled low through the enables
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	assign interrupt_out_n = 1'b0;
	assign scl_oe = st.scl_oe;
	assign sda_oe = st.sda_oe;
	assign interrupt_out_oe = st.int_oe;
	assign fwd = st.fwd;
	assign audio = st.audio;
	assign cfg = st.cfg;

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	a_strap_hold: assert property (@(posedge mclk) disable iff (!reset_n)
		st.loaded |=> $stable(st.mode_code) && $stable(st.addr_code))
		else $error("strap code changed after capture");
	a_mode_strap: assert property (@(posedge mclk) disable iff (!reset_n)
		(st.loaded && !st.regs[MSRC_REG_MODE_OVR][MSRC_BIT_OVR_EN]) |=>
		cfg.mode.repeater == $past(strap_mode.repeater))
		else $error("repeater does not follow strap");
	a_chb_video: assert property (@(posedge mclk) disable iff (!reset_n)
		!cfg.mode.second_audio |=> !audio.second_data && (cfg.video_18bit == cfg.mode.second_audio))
		else $error("second audio passed while disabled");
	a_gpio_reg: assert property (@(posedge mclk) disable iff (!reset_n)
		##1 cfg.gpio_en == $past(st.regs[MSRC_REG_GPIO_EN][MSRC_GPIO_W-1:0]))
		else $error("gpio enable not from register");
	a_sec_reg: assert property (@(posedge mclk) disable iff (!reset_n)
		st.regs[MSRC_REG_SEC_AUDIO][MSRC_BIT_SEC_AUDIO] |=> cfg.mode.second_audio)
		else $error("register did not enable secondary audio");
	a_write_ack: assert property (@(posedge mclk) disable iff (!reset_n)
		(scl_fall && st.ph == MSRC_ST_WDATA && st.cnt == MSRC_BITS_BYTE && !bus_start
		&& !bus_stop && !st.stretch) |=> sda_oe && st.ph == MSRC_ST_ACK)
		else $error("write byte not acknowledged");
	a_addr_strap: assert property (@(posedge mclk) disable iff (!reset_n)
		!st.regs[MSRC_REG_DEV_ID][MSRC_BIT_ID_OVR] |=> cfg.dev_addr == $past(strap_addr))
		else $error("address does not follow strap");
	a_int_chain: assert property (@(posedge mclk) disable iff (!reset_n)
		(cfg.mode.repeater && !interrupt_in_n) |=> interrupt_out_oe && !interrupt_out_n)
		else $error("downstream interrupt not chained");
	a_stretch_cause: assert property (@(posedge mclk) disable iff (!reset_n)
		$rose(scl_oe) |-> !$past(fwd.valid) && fwd.valid && !fwd.write)
		else $error("clock stretched without forwarded read");
	a_fwd_repeat: assert property (@(posedge mclk) disable iff (!reset_n)
		fwd.valid |-> cfg.mode.repeater && !st.own)
		else $error("forwarding outside repeater mode");

endmodule

// ### verilog/msrc_pkg.sv
// shared constants and types of the mode strap and repeater configuration block
package msrc_pkg;

	// ------------------------------------------------------------------
	// register indices reached over the two-wire target
	// ------------------------------------------------------------------
	localparam int MSRC_REG_NUM = 32;
	localparam logic [7:0] MSRC_REG_DEV_ID = 8'h00;
	localparam logic [7:0] MSRC_REG_SEC_AUDIO = 8'h12;
	localparam logic [7:0] MSRC_REG_MODE_OVR = 8'h13;
	localparam logic [7:0] MSRC_REG_GPIO_EN = 8'h14;
	localparam logic [7:0] MSRC_REG_ALIAS_ID = 8'h15;
	localparam logic [7:0] MSRC_REG_ALIAS_TGT = 8'h18;
	localparam logic [7:0] MSRC_REG_AUDIO_PATH = 8'h1B;
	localparam logic [7:0] MSRC_REG_STATUS = 8'h1C;
	localparam int MSRC_ALIAS_NUM = 3;

	// ------------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------------
	localparam int MSRC_BIT_ID_OVR = 0;
	localparam int MSRC_BIT_SEC_AUDIO = 0;
	localparam int MSRC_BIT_OVR_EN = 0;
	localparam int MSRC_BIT_OVR_FREQ = 1;
	localparam int MSRC_BIT_OVR_REP = 2;
	localparam int MSRC_BIT_OVR_BC = 3;
	localparam int MSRC_BIT_OVR_CHB = 4;
	localparam int MSRC_BIT_AUDIO_SERIAL = 0;
	localparam int MSRC_GPIO_W = 4;

	// ------------------------------------------------------------------
	// strap tables and bus constants
	// ------------------------------------------------------------------
	localparam logic [6:0] MSRC_ADDR_TABLE [0:8] = '{7'h0C, 7'h0D, 7'h0E, 7'h0F, 7'h10,
		7'h13, 7'h14, 7'h15, 7'h1B};
	localparam logic [3:0] MSRC_ADDR_CODES = 4'h9;
	localparam logic [3:0] MSRC_BITS_BYTE = 4'h8;
	localparam logic [3:0] MSRC_CNT_ZERO = 4'h0;
	localparam logic [3:0] MSRC_CNT_ONE = 4'h1;
	localparam logic [7:0] MSRC_BYTE_ZERO = 8'h00;
	localparam logic [7:0] MSRC_PTR_ONE = 8'h01;

	typedef enum logic [2:0] {
		MSRC_ST_IDLE,
		MSRC_ST_ADDR,
		MSRC_ST_REG,
		MSRC_ST_WDATA,
		MSRC_ST_RDATA,
		MSRC_ST_ACK,
		MSRC_ST_MACK
	} msrc_phase_e;

	// decoded operating mode
	typedef struct packed {
		logic freq_high;
		logic repeater;
		logic backward_compat;
		logic second_audio;
	} msrc_mode_s;

	// configuration presented to the rest of the serializer
	typedef struct packed {
		msrc_mode_s mode;
		logic video_18bit;
		logic audio_serial;
		logic [MSRC_GPIO_W-1:0] gpio_en;
		logic [6:0] dev_addr;
	} msrc_cfg_s;

	// one forwarded byte toward a downstream target
	typedef struct packed {
		logic valid;
		logic write;
		logic [6:0] target;
		logic [7:0] data;
	} msrc_fwd_s;

	// audio lines after enable gating
	typedef struct packed {
		logic first_data;
		logic second_data;
		logic word_select;
	} msrc_audio_s;

endpackage

// ### verilog/msrc_strap_decode.sv
// strap code decoder for operating mode and target address
`timescale 1ns/10ps
module msrc_strap_decode (
	// strap codes
	input wire logic [2:0] mode_code,
	input wire logic [3:0] addr_code,
	// decoded values
	output msrc_pkg::msrc_mode_s mode,
	output logic [6:0] addr
);
	import msrc_pkg::*;

	// mode table, one code per strap level
	always_comb begin
		case (mode_code)
			3'h0: mode = '{1'b0, 1'b0, 1'b0, 1'b0};
			3'h1: mode = '{1'b0, 1'b1, 1'b0, 1'b0};
			3'h2: mode = '{1'b0, 1'b1, 1'b0, 1'b1};
			3'h3: mode = '{1'b1, 1'b0, 1'b0, 1'b0};
			3'h4: mode = '{1'b1, 1'b0, 1'b0, 1'b1};
			3'h5: mode = '{1'b1, 1'b1, 1'b0, 1'b0};
			3'h6: mode = '{1'b1, 1'b1, 1'b0, 1'b1};
			default: mode = '{1'b1, 1'b0, 1'b1, 1'b0};
		endcase
	end

	// out-of-range address codes fall back to the lowest address
	always_comb begin
		if (addr_code < MSRC_ADDR_CODES) begin
			addr = MSRC_ADDR_TABLE[addr_code];
		end else begin
			addr = MSRC_ADDR_TABLE[0];
		end
	end

endmodule
